// file: core/pcs_cfg_regs.sv
// configuration and clock shift registers behind the indirect access port
// assumes a host that writes and reads the port one byte per strobe,
// all inputs synchronous to clk
`include "pcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pcs_cfg_regs
   import pcs_pkg::*;
#(
   parameter int BUSY_CYC = `PCS_BUSY_CYC
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       iap_wr_stb,
   input  wire logic       iap_rd_stb,
   input  wire logic [7:0] iap_wdata,
   output logic      [7:0] iap_rdata,
   output logic            iap_busy,
   output logic            clock_period_select,
   output logic            line_config_select,
   output logic            function_select,
   output logic            law_select,
   output logic      [1:0] byte_format,
   output logic      [3:0] rx_offset_half,
   output logic      [3:0] tx_offset_half,
   output logic            rx_sample_rising,
   output logic            tx_launch_falling,
   output logic            slot_lag,
   output logic            frames_aligned,
   input  wire logic       sys_bit_stb,
   input  wire logic       sys_rx_bit,
   input  wire logic       sys_tx_bit,
   output logic            sys_rx_data,
   output logic            sys_tx_data,
   input  wire logic [7:0] pcm_byte_in,
   output logic      [7:0] pcm_byte_out
);

   // ========================================================================
   // declarations
   logic [7:0] device_configuration;
   logic [7:0] frame_clock_shift;
   pcs_phase_t wr_phase;
   pcs_phase_t rd_phase;
   logic [7:0] ctl_byte;
   logic [7:0] data_byte;
   logic [7:0] addr_byte;
   logic [7:0] next_data_byte;
   logic [5:0] busy_cnt;
   logic       wr_take;
   logic       rd_take;
   logic       access_done;
   pcs_cmd_t   cmd;
   logic       primary;
   logic [2:0] eff_rx_shift;
   logic [2:0] eff_tx_shift;
   logic       eff_rx_edge;
   logic       eff_tx_edge;
   logic [7:0] fmt_byte;

   pcs_delay_if #(.SW(3)) rx_line ();
   pcs_delay_if #(.SW(3)) tx_line ();

   // ========================================================================
   // indirect access port sequencing
   // bytes arriving while busy are dropped, as the host must poll busy first
   assign wr_take     = iap_wr_stb & ~iap_busy;
   assign rd_take     = iap_rd_stb & ~iap_busy & ~iap_wr_stb;
   assign access_done = wr_take & (wr_phase == pcs_ph_addr);
   assign cmd         = ctl_byte[`PCS_CMD_HI:`PCS_CMD_LO];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_phase <= pcs_ph_ctrl;
      end else if (wr_take) begin
         unique case (wr_phase)
            pcs_ph_ctrl: wr_phase <= pcs_ph_data;
            pcs_ph_data: wr_phase <= pcs_ph_addr;
            pcs_ph_addr: wr_phase <= pcs_ph_ctrl;
            default:     wr_phase <= pcs_ph_ctrl;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_byte <= 8'h00;
      end else if (wr_take && wr_phase == pcs_ph_ctrl) begin
         ctl_byte <= iap_wdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_byte <= 8'h00;
      end else if (access_done) begin
         addr_byte <= iap_wdata;
      end
   end

   // a read command replaces the data byte with the addressed register
   always_comb begin
      next_data_byte = data_byte;
      if (wr_take && wr_phase == pcs_ph_data) begin
         next_data_byte = iap_wdata;
      end else if (access_done && cmd == `PCS_CMD_RD_REG) begin
         if (iap_wdata == `PCS_ADDR_CONFIG) begin
            next_data_byte = device_configuration | `PCS_CONFIG_FIXED;
         end else if (iap_wdata == `PCS_ADDR_SHIFT) begin
            next_data_byte = frame_clock_shift;
         end else begin
            next_data_byte = `PCS_READ_UNMAPPED;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_byte <= 8'h00;
      end else begin
         data_byte <= next_data_byte;
      end
   end

   // ========================================================================
   // busy time after every completed three-byte access
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt <= 6'h00;
      end else if (access_done) begin
         busy_cnt <= 6'(BUSY_CYC);
      end else if (busy_cnt != 6'h00) begin
         busy_cnt <= busy_cnt - 6'h01;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         iap_busy <= 1'b0;
      end else begin
         iap_busy <= access_done | (busy_cnt > 6'h01);
      end
   end

   // ========================================================================
   // read back of the three port bytes: control, data, address
   // any write taken while not busy restarts the read sequence at the control byte
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_phase <= pcs_ph_ctrl;
      end else if (wr_take) begin
         rd_phase <= pcs_ph_ctrl;
      end else if (rd_take) begin
         unique case (rd_phase)
            pcs_ph_ctrl: rd_phase <= pcs_ph_data;
            pcs_ph_data: rd_phase <= pcs_ph_addr;
            pcs_ph_addr: rd_phase <= pcs_ph_ctrl;
            default:     rd_phase <= pcs_ph_ctrl;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         iap_rdata <= 8'h00;
      end else if (rd_take) begin
         unique case (rd_phase)
            pcs_ph_ctrl: iap_rdata <= ctl_byte;
            pcs_ph_data: iap_rdata <= data_byte;
            pcs_ph_addr: iap_rdata <= addr_byte;
            default:     iap_rdata <= 8'h00;
         endcase
      end
   end

   // ========================================================================
   // configuration register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         device_configuration <= `PCS_CONFIG_RESET;
      end else if (access_done && cmd == `PCS_CMD_WR_REG
                   && iap_wdata == `PCS_ADDR_CONFIG) begin
         // the two top bits are not writable
         device_configuration <= data_byte | `PCS_CONFIG_FIXED;
      end
   end

   // ========================================================================
   // clock shift register
   // it is cleared when the standard configuration is chosen, and a write
   // in that configuration stores zero, so no stale shift can survive
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_clock_shift <= `PCS_SHIFT_RESET;
      end else if (access_done && cmd == `PCS_CMD_WR_REG) begin
         if (iap_wdata == `PCS_ADDR_SHIFT) begin
            if (device_configuration[`PCS_BIT_LINE_SEL]) begin
               frame_clock_shift <= `PCS_SHIFT_RESET;
            end else begin
               frame_clock_shift <= data_byte;
            end
         end else if (iap_wdata == `PCS_ADDR_CONFIG
                      && data_byte[`PCS_BIT_LINE_SEL]) begin
            frame_clock_shift <= `PCS_SHIFT_RESET;
         end
      end
   end

   // ========================================================================
   // configuration outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clock_period_select <= 1'b1;
         line_config_select  <= 1'b1;
         function_select     <= 1'b1;
         law_select          <= 1'b1;
         byte_format         <= 2'h3;
      end else begin
         clock_period_select <= device_configuration[`PCS_BIT_CLK_SEL];
         line_config_select  <= device_configuration[`PCS_BIT_LINE_SEL];
         function_select     <= device_configuration[`PCS_BIT_FUNC_SEL];
         law_select          <= device_configuration[`PCS_BIT_LAW_SEL];
         byte_format         <= device_configuration[`PCS_FMT_HI:`PCS_FMT_LO];
      end
   end

   // ========================================================================
   // effective shift and edge settings
   // standard configuration forces them off whatever is stored
   assign primary      = ~device_configuration[`PCS_BIT_LINE_SEL];
   assign eff_rx_shift = primary ? frame_clock_shift[`PCS_RX_SHIFT_HI:`PCS_RX_SHIFT_LO]
                                 : 3'h0;
   assign eff_tx_shift = primary ? frame_clock_shift[`PCS_TX_SHIFT_HI:`PCS_TX_SHIFT_LO]
                                 : 3'h0;
   assign eff_rx_edge  = primary & frame_clock_shift[`PCS_RX_EDGE_BIT];
   assign eff_tx_edge  = primary & frame_clock_shift[`PCS_TX_EDGE_BIT];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_sample_rising  <= 1'b0;
         tx_launch_falling <= 1'b0;
      end else begin
         rx_sample_rising  <= eff_rx_edge;
         tx_launch_falling <= eff_tx_edge;
      end
   end

   // offsets from the sync edge in half clock periods, at most fifteen
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_offset_half <= 4'h0;
         tx_offset_half <= 4'h0;
      end else begin
         rx_offset_half <= {eff_rx_shift, eff_rx_edge};
         tx_offset_half <= {eff_tx_shift, eff_tx_edge};
      end
   end

   // ========================================================================
   // slot relation between input and output frames
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slot_lag       <= 1'b0;
         frames_aligned <= 1'b1;
      end else begin
         slot_lag       <= (eff_rx_shift == eff_tx_shift) && (eff_rx_shift != 3'h0)
                           && (eff_rx_edge == eff_tx_edge);
         frames_aligned <= (eff_rx_shift == 3'h0) && (eff_tx_shift == 3'h0)
                           && !eff_rx_edge && !eff_tx_edge;
      end
   end

   // ========================================================================
   // system interface delay lines
   assign rx_line.stb    = sys_bit_stb;
   assign rx_line.bit_in = sys_rx_bit;
   assign rx_line.steps  = eff_rx_shift;
   assign tx_line.stb    = sys_bit_stb;
   assign tx_line.bit_in = sys_tx_bit;
   assign tx_line.steps  = eff_tx_shift;

   pcs_bit_delay #(.DEPTH(7)) u_rx_delay (
      .clk     (clk),
      .sys_rst (sys_rst),
      .dl      (rx_line.line)
   );

   pcs_bit_delay #(.DEPTH(7)) u_tx_delay (
      .clk     (clk),
      .sys_rst (sys_rst),
      .dl      (tx_line.line)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sys_rx_data <= 1'b0;
         sys_tx_data <= 1'b0;
      end else begin
         sys_rx_data <= rx_line.bit_out;
         sys_tx_data <= tx_line.bit_out;
      end
   end

   // ========================================================================
   // pcm byte format applied to conference data
   // the registered format field drives the inverter, so the byte output
   // always agrees with the byte_format pins one cycle earlier
   pcs_byte_fmt u_fmt (
      .fmt      (byte_format),
      .byte_in  (pcm_byte_in),
      .byte_out (fmt_byte)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pcm_byte_out <= 8'h00;
      end else begin
         pcm_byte_out <= fmt_byte;
      end
   end

endmodule

`default_nettype wire

// file: core/pcs_consts.svh
// constants for the pcm switch configuration register bank
// assumes inclusion by bare name from the core design files
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ==========================================================================
// indirect addresses and reset values
`define PCS_ADDR_CONFIG    8'hfe
`define PCS_ADDR_SHIFT     8'hff
`define PCS_CONFIG_RESET   8'hff
`define PCS_SHIFT_RESET    8'h00
`define PCS_CONFIG_FIXED   8'hc0
`define PCS_READ_UNMAPPED  8'h00

// ==========================================================================
// field positions of the configuration register
`define PCS_BIT_CLK_SEL    0
`define PCS_BIT_LINE_SEL   1
`define PCS_BIT_FUNC_SEL   2
`define PCS_BIT_LAW_SEL    3
`define PCS_FMT_LO         4
`define PCS_FMT_HI         5

// ==========================================================================
// field positions of the clock shift register
`define PCS_RX_SHIFT_HI    7
`define PCS_RX_SHIFT_LO    5
`define PCS_RX_EDGE_BIT    4
`define PCS_TX_SHIFT_HI    3
`define PCS_TX_SHIFT_LO    1
`define PCS_TX_EDGE_BIT    0

// ==========================================================================
// control byte command field and codes
`define PCS_CMD_HI         7
`define PCS_CMD_LO         5
`define PCS_CMD_WR_REG     3'h7
`define PCS_CMD_RD_REG     3'h6

// ==========================================================================
// byte inversion masks
`define PCS_MASK_EVEN      8'h55
`define PCS_MASK_ODD       8'haa
`define PCS_MASK_ALL       8'hff

// ==========================================================================
// timing
`define PCS_SYS_CLK_MHZ    50
`define PCS_BUSY_NS        900
`define PCS_BUSY_CYC       ((`PCS_BUSY_NS * `PCS_SYS_CLK_MHZ) / 1000)

`endif

// file: core/pcs_pkg.sv
// types shared by the pcm switch configuration register bank
// assumes nothing of its surroundings
`default_nettype none

package pcs_pkg;

   typedef enum logic [1:0] {pcs_ph_ctrl, pcs_ph_data, pcs_ph_addr} pcs_phase_t;

   typedef enum logic [1:0] {pcs_fmt_none, pcs_fmt_even, pcs_fmt_odd, pcs_fmt_all} pcs_fmt_t;

   typedef logic [2:0] pcs_cmd_t;

endpackage

`default_nettype wire

// file: core/pcs_delay_if.sv
// carrier between the register bank and its bit delay lines
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface pcs_delay_if #(parameter int SW = 3);
   logic          stb;
   logic          bit_in;
   logic [SW-1:0] steps;
   logic          bit_out;

   modport src  (output stb, output bit_in, output steps, input bit_out);
   modport line (input stb, input bit_in, input steps, output bit_out);
endinterface

`default_nettype wire

// file: core/pcs_bit_delay.sv
// programmable bit-period delay line for one serial stream
// assumes one strobe per bit period, synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module pcs_bit_delay #(
   parameter int DEPTH = 7
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   pcs_delay_if.line dl
);

   logic [DEPTH-1:0] hist;

   // ========================================================================
   // history of past bits, one entry per bit period
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hist <= '0;
      end else if (dl.stb) begin
         hist <= {hist[DEPTH-2:0], dl.bit_in};
      end
   end

   // zero steps passes the stream straight through, keeping frames aligned
   always_comb begin
      if (dl.steps == '0) begin
         dl.bit_out = dl.bit_in;
      end else begin
         dl.bit_out = hist[dl.steps - 1'b1];
      end
   end

endmodule

`default_nettype wire

// file: core/pcs_byte_fmt.sv
// pcm byte inversion for the selected byte format
// assumes a purely combinational use inside a registered path
`include "pcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pcs_byte_fmt
   import pcs_pkg::*;
(
   input  wire logic [1:0] fmt,
   input  wire logic [7:0] byte_in,
   output logic      [7:0] byte_out
);

   always_comb begin
      unique case (pcs_fmt_t'(fmt))
         pcs_fmt_none: byte_out = byte_in;
         pcs_fmt_even: byte_out = byte_in ^ `PCS_MASK_EVEN;
         pcs_fmt_odd:  byte_out = byte_in ^ `PCS_MASK_ODD;
         pcs_fmt_all:  byte_out = byte_in ^ `PCS_MASK_ALL;
      endcase
   end

endmodule

`default_nettype wire

// file: sim/pcs_cfg_regs_props.sv
// checker for the configuration register bank, ports of pcs_cfg_regs only
// assumes one clock domain and a bind onto every instance of pcs_cfg_regs
`timescale 1ns/1ps
`default_nettype none

module pcs_cfg_regs_props #(
   parameter int BUSY_CYC = 45
) (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       iap_wr_stb,
   input wire logic       iap_rd_stb,
   input wire logic [7:0] iap_rdata,
   input wire logic       iap_busy,
   input wire logic       clock_period_select,
   input wire logic       line_config_select,
   input wire logic       function_select,
   input wire logic       law_select,
   input wire logic [1:0] byte_format,
   input wire logic [3:0] rx_offset_half,
   input wire logic [3:0] tx_offset_half,
   input wire logic       rx_sample_rising,
   input wire logic       tx_launch_falling,
   input wire logic       slot_lag,
   input wire logic       frames_aligned,
   input wire logic [7:0] pcm_byte_in,
   input wire logic [7:0] pcm_byte_out
);
   // ======================================================================
   // helper logic
   logic [1:0] wph;
   logic       rdy;
   int         bcnt;
   logic       wr_ok;
   logic       rd_ok;
   logic       wr3;
   logic [7:0] exp_fmt;

   assign wr_ok = iap_wr_stb && !iap_busy;
   assign rd_ok = iap_rd_stb && !iap_wr_stb && !iap_busy;
   assign wr3 = wr_ok && (wph == 2'h2);
   assign exp_fmt = pcm_byte_in ^ ((byte_format == 2'h0) ? 8'h00 :
                                   (byte_format == 2'h1) ? 8'h55 :
                                   (byte_format == 2'h2) ? 8'haa : 8'hff);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wph <= 2'h0;
      end else if (wr_ok) begin
         wph <= (wph == 2'h2) ? 2'h0 : wph + 2'h1;
      end
   end

   // $past is meaningless on the first edge after reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdy <= 1'b0;
      end else begin
         rdy <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bcnt <= 0;
      end else begin
         bcnt <= iap_busy ? bcnt + 1 : 0;
      end
   end

   // ======================================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_busy_start: assert property (wr3 |=> iap_busy)
      else $error("busy did not follow the address byte");
   a_busy_cause: assert property ($rose(iap_busy) |-> $past(wr3))
      else $error("busy rose without a completed access");
   a_busy_length: assert property ($fell(iap_busy) |-> bcnt == BUSY_CYC)
      else $error("busy period has the wrong length");
   a_cfg_moves: assert property (rdy && !$stable({clock_period_select, line_config_select,
      function_select, law_select, byte_format, rx_offset_half, tx_offset_half})
      |-> $past(wr3, 2))
      else $error("configuration output changed without an access");
   a_rdata_hold: assert property (rdy && !$stable(iap_rdata) |-> $past(rd_ok))
      else $error("read data changed without a taken read");
   a_fmt_apply: assert property (rdy |-> pcm_byte_out == $past(exp_fmt))
      else $error("pcm byte not formatted as selected");
   a_std_zero: assert property (line_config_select |->
      rx_offset_half == 4'h0 && tx_offset_half == 4'h0)
      else $error("shift active in standard configuration");
   a_lag_match: assert property (slot_lag == (rx_offset_half == tx_offset_half &&
      rx_offset_half[3:1] != 3'h0))
      else $error("slot lag flag wrong");
   a_align_match: assert property (frames_aligned ==
      (rx_offset_half == 4'h0 && tx_offset_half == 4'h0))
      else $error("frame alignment flag wrong");
   a_edge_bits: assert property (rx_sample_rising == rx_offset_half[0] &&
      tx_launch_falling == tx_offset_half[0])
      else $error("edge selects disagree with offsets");
endmodule

bind pcs_cfg_regs pcs_cfg_regs_props #(.BUSY_CYC(BUSY_CYC)) u_props (
   .clk, .sys_rst, .iap_wr_stb, .iap_rd_stb, .iap_rdata, .iap_busy, .clock_period_select,
   .line_config_select, .function_select, .law_select, .byte_format, .rx_offset_half,
   .tx_offset_half, .rx_sample_rising, .tx_launch_falling, .slot_lag, .frames_aligned,
   .pcm_byte_in, .pcm_byte_out);

`default_nettype wire

// file: sim/pcs_host_model.sv
// host microprocessor model driving the three-byte indirect access port
// assumes strobes are sampled on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none

module pcs_host_model (
   input  wire logic       clk,
   input  wire logic       iap_busy,
   input  wire logic [7:0] iap_rdata,
   output logic            iap_wr_stb,
   output logic            iap_rd_stb,
   output logic      [7:0] iap_wdata
);
   initial begin
      iap_wr_stb = 1'b0;
      iap_rd_stb = 1'b0;
      iap_wdata  = 8'h00;
   end

   task automatic idle_wait();
      @(posedge clk);
      while (iap_busy) @(posedge clk);
   endtask

   // control, data and address bytes back to back
   task automatic access(input logic [2:0] cmd, input logic [7:0] data, input logic [7:0] addr);
      idle_wait();
      iap_wr_stb <= 1'b1;
      iap_wdata  <= {cmd, 5'h00};
      @(posedge clk);
      iap_wdata <= data;
      @(posedge clk);
      iap_wdata <= addr;
      @(posedge clk);
      iap_wr_stb <= 1'b0;
      // released data lines show no stale byte
      iap_wdata <= ~addr;
      repeat (2) @(posedge clk);
   endtask

   // read command, then three read strobes; the data byte carries the value
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] val);
      access(3'h6, 8'h00, addr);
      idle_wait();
      iap_rd_stb <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         if (i == 2) iap_rd_stb <= 1'b0;
         #1;
         if (i == 1) val = iap_rdata;
      end
   endtask
endmodule

`default_nettype wire

// file: sim/pcs_cfg_regs_test.sv
// self-checking bench for the configuration register bank
// assumes pcs_host_model and the bound checker are compiled beforehand
`timescale 1ns/1ps
`default_nettype none

module pcs_cfg_regs_test;
   localparam int BUSY = 2;
   logic       clk, sys_rst, iap_wr_stb, iap_rd_stb, iap_busy, slot_lag, frames_aligned;
   logic       clock_period_select, line_config_select, function_select, law_select;
   logic       rx_sample_rising, tx_launch_falling, sys_bit_stb, sys_rx_bit, sys_tx_bit;
   logic       sys_rx_data, sys_tx_data;
   logic [7:0] iap_wdata, iap_rdata, pcm_byte_in, pcm_byte_out, rv, cv;
   logic [1:0] byte_format;
   logic [3:0] rx_offset_half, tx_offset_half;
   logic [11:0] p;
   logic [7:0] mask [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
   logic [7:0] sv [4] = '{8'h55, 8'hff, 8'h11, 8'h40};
   logic       lag_x [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   int         err_total, n_checks, cyc;

   pcs_cfg_regs #(.BUSY_CYC(BUSY)) dut (.clk, .sys_rst, .iap_wr_stb, .iap_rd_stb, .iap_wdata,
      .iap_rdata, .iap_busy, .clock_period_select, .line_config_select, .function_select,
      .law_select, .byte_format, .rx_offset_half, .tx_offset_half, .rx_sample_rising,
      .tx_launch_falling, .slot_lag, .frames_aligned, .sys_bit_stb, .sys_rx_bit, .sys_tx_bit,
      .sys_rx_data, .sys_tx_data, .pcm_byte_in, .pcm_byte_out);
   pcs_host_model host (.clk, .iap_busy, .iap_rdata, .iap_wr_stb, .iap_rd_stb, .iap_wdata);

   initial clk = 1'b0;
   always #10 clk = ~clk;

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // a full run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         print_verdict();
      end
   end

   // ======================================================================
   // main sequence
   initial begin
      sys_rst = 1'b1;
      sys_bit_stb = 1'b0;
      sys_rx_bit = 1'b0;
      sys_tx_bit = 1'b0;
      pcm_byte_in = 8'h3c;
      err_total = 0;
      n_checks = 0;
      cyc = 0;
      p = 12'hb4d;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk("cfg outputs", {clock_period_select, line_config_select, function_select, law_select,
         byte_format}, 8'h3f);
      chk("aligned", frames_aligned, 8'h01);
      host.read_reg(8'hfe, rv);
      chk("cfg reset", rv, 8'hff);
      host.read_reg(8'hff, rv);
      chk("shift reset", rv, 8'h00);
      for (int i = 0; i < 4; i++) begin
         cv = {2'b00, i[1:0], i[0], i[1], 1'b0, i[0]};
         @(posedge clk);
         pcm_byte_in <= 8'h3c ^ cv;
         host.access(3'h7, cv, 8'hfe);
         @(negedge clk);
         chk("cfg fields", {clock_period_select, line_config_select, function_select, law_select,
            byte_format}, {2'b00, cv[0], cv[1], cv[2], cv[3], cv[5:4]});
         chk("pcm byte", pcm_byte_out, 8'h3c ^ cv ^ mask[i]);
         host.read_reg(8'hfe, rv);
         chk("cfg read", rv, cv | 8'hc0);
      end
      for (int j = 0; j < 4; j++) begin
         host.access(3'h7, sv[j], 8'hff);
         @(negedge clk);
         chk("rx offset", rx_offset_half, {sv[j][7:5], sv[j][4]});
         chk("tx offset", tx_offset_half, {sv[j][3:1], sv[j][0]});
         chk("slot lag", slot_lag, lag_x[j]);
         chk("not aligned", frames_aligned, {7'h00, sv[j] == 8'h00});
         chk("edges", {rx_sample_rising, tx_launch_falling}, {sv[j][4], sv[j][0]});
         host.read_reg(8'hff, rv);
         chk("shift read", rv, sv[j]);
      end
      for (int k = 0; k < 12; k++) begin
         @(posedge clk);
         sys_bit_stb <= 1'b1;
         sys_rx_bit <= p[k];
         sys_tx_bit <= !p[k];
         @(posedge clk);
         sys_bit_stb <= 1'b0;
         sys_rx_bit <= !p[k];
         @(negedge clk);
         if (k >= 2) chk("rx stream", sys_rx_data, p[k-2]);
         chk("tx stream", sys_tx_data, !p[k]);
      end
      host.access(3'h7, 8'h02, 8'hfe);
      @(negedge clk);
      chk("std offsets", {rx_offset_half, tx_offset_half}, 8'h00);
      host.read_reg(8'hff, rv);
      chk("std clears", rv, 8'h00);
      // the host breaks its side here on purpose
      host.access(3'h7, 8'h55, 8'hff);
      host.read_reg(8'hff, rv);
      chk("std refuses", rv, 8'h00);
      host.access(3'h7, 8'h11, 8'h7a);
      host.access(3'h1, 8'h00, 8'hfe);
      host.read_reg(8'h7a, rv);
      chk("unmapped", rv, 8'h00);
      host.read_reg(8'hfe, rv);
      chk("cfg kept", rv, 8'hc2);
      print_verdict();
   end
endmodule

`default_nettype wire
